/* File: verilog/sedo_map.svh */
// Register offsets, field positions, codes and reset values of the servo enable block.
`ifndef SEDO_MAP_SVH
`define SEDO_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SEDO_ADDR_W          4
`define SEDO_ADDR_CTRL       4'h0
`define SEDO_ADDR_STATUS     4'h4
`define SEDO_ADDR_THRESH     4'h8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SEDO_CTRL_ROUTE_LSB  0
`define SEDO_CTRL_ROUTE_MSB  3
`define SEDO_CTRL_DIR_BIT    4
`define SEDO_CTRL_CLAMP_BIT  5
`define SEDO_CTRL_ARST_BIT   8

// ----------------------------------------------------------------------------
// Servo-on routing codes and reset values
// ----------------------------------------------------------------------------
`define SEDO_ROUTE_PIN       4'h0
`define SEDO_ROUTE_FORCED    4'h9
`define SEDO_ROUTE_RST       4'h0
`define SEDO_THRESH_RST      16'h0010
`define SEDO_THRESH_W        16
`define SEDO_WORD_ZERO       32'h0000_0000
`define SEDO_CMD_ZERO        16'h0000

// ----------------------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------------------
`define SEDO_STAT_ENERGIZED  0
`define SEDO_STAT_OT_FWD     1
`define SEDO_STAT_OT_REV     2
`define SEDO_STAT_BRAKE_ON   3
`define SEDO_STAT_CLAMP      4
`define SEDO_STAT_BBLOCK     5
`define SEDO_STAT_FAULT      6
`define SEDO_STAT_STILL      7
`define SEDO_STAT_REQ        8

`endif

/* File: verilog/sedo_pkg.sv */
// Types shared by the servo enable, direction and overtravel block.
`include "sedo_map.svh"

package sedo_pkg;

    // ------------------------------------------------------------------------
    // Energize state machine
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEDO_ST_OFF   = 2'b00,
        SEDO_ST_ON    = 2'b01,
        SEDO_ST_FAULT = 2'b10
    } sedo_state_t;

    // ------------------------------------------------------------------------
    // Software configuration
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] route;
        logic       dir_cw;
        logic       ot_clamp;
    } sedo_cfg_t;

    // ------------------------------------------------------------------------
    // Complete state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed {
        sedo_state_t                st;
        sedo_cfg_t                  cfg;
        logic [`SEDO_THRESH_W-1:0]  thresh;
        logic                       arst;
        logic                       wait_n;
        logic [31:0]                rdata;
        logic                       motor_en;
        logic signed [15:0]         drive_cmd;
        logic                       brake_rel;
        logic                       clamp;
        logic                       bblock;
        logic                       pulse_a;
        logic                       pulse_b;
    } sedo_regs_t;

endpackage

/* File: verilog/sedo_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous input pins.
`timescale 1ns/1ps

module sedo_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    // Pins and synchronised copy
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sedo_sync_t;

    sedo_sync_t q;
    sedo_sync_t q_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        q_nxt        = q;
        q_nxt.meta   = async_i;
        q_nxt.stable = q.meta;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= q_nxt;
        end
    end

    assign sync_o = q.stable;

endmodule

/* File: verilog/sedo_top.sv */
// Servo enable, rotation direction and overtravel control with an Avalon-MM register slave.
//
// Functional notes
// - Servo-on active energizes the motor; inactive keeps it unpowered and undriven.
// - Routing field can take servo-on from any general input terminal.
// - Energize is refused while the motor rotates; only granted at standstill.
// - Routing value 0 uses the servo-on pin; value 9 forces servo-on active.
// - Forced mode energizes as soon as main power is present and the shaft is at rest.
// - Forced mode returns to energized after an alarm reset clears a fault.
// - Direction field 0 maps positive command to COUNTERCLOCKWISE, 1 to CW.
// - Divided pulse phase relation is unchanged by the direction field.
// - Forward limit blocks forward motion, reverse limit blocks reverse motion.
// - After an overtravel stop without clamp the drive enters base block.
// - Brake output stays applied while in the overtravel state.
// - Stop-state field 1 holds a zero clamp instead of base block.
// - Motion opposite to a blocked direction is still accepted.
// - Limit input ON permits motion; OFF signals overtravel on that side.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sedo_map.svh"

module sedo_top #(
    parameter int NUM_TERMS = 8
) (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // Avalon-MM register slave
    input  wire logic [`SEDO_ADDR_W-1:0] avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    // Input pins, asynchronous
    input  wire logic                    servo_on_n_i,
    input  wire logic [NUM_TERMS-1:0]    input_terms_n_i,
    input  wire logic                    forward_limit_in_i,
    input  wire logic                    reverse_limit_in_i,
    input  wire logic                    main_power_i,
    input  wire logic                    enc_a_i,
    input  wire logic                    enc_b_i,
    // Internal drive signals, same clock
    input  wire logic                    alarm_i,
    input  wire logic signed [15:0]      motor_speed_i,
    input  wire logic signed [15:0]      cmd_i,
    // Drive outputs
    output logic                         motor_enable_o,
    output logic signed [15:0]           drive_cmd_o,
    output logic                         brake_release_out_o,
    output logic                         zero_clamp_o,
    output logic                         base_block_o,
    output logic                         divided_pulse_a_o,
    output logic                         divided_pulse_b_o
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        logic [15:0] r;
        r = v[15] ? 16'(-v) : 16'(v);
        return r;
    endfunction

    // Saturating negation so that the most negative value cannot wrap.
    function automatic logic signed [15:0] neg16(input logic signed [15:0] v);
        logic signed [15:0] r;
        r = (v == 16'sh8000) ? 16'sh7fff : 16'(-v);
        return r;
    endfunction

    function automatic logic route_select(input logic [3:0] route,
                                          input logic son_n,
                                          input logic [NUM_TERMS-1:0] terms_n);
        logic r;
        r = 1'b0;
        if (route == `SEDO_ROUTE_PIN) begin
            r = ~son_n;
        end else if (route == `SEDO_ROUTE_FORCED) begin
            r = 1'b1;
        end else if (int'(route) <= NUM_TERMS) begin
            r = ~terms_n[int'(route) - 1];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    localparam int SYNC_W = NUM_TERMS + 6;

    logic [SYNC_W-1:0]    sync_w;
    logic                 s_son_n;
    logic [NUM_TERMS-1:0] s_terms_n;
    logic                 s_fwd_ok;
    logic                 s_rev_ok;
    logic                 s_power;
    logic                 s_enc_a;
    logic                 s_enc_b;

    sedo_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({servo_on_n_i, input_terms_n_i, forward_limit_in_i,
                   reverse_limit_in_i, main_power_i, enc_a_i, enc_b_i}),
        .sync_o  (sync_w)
    );

    assign {s_son_n, s_terms_n, s_fwd_ok, s_rev_ok, s_power, s_enc_a, s_enc_b} = sync_w;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    sedo_pkg::sedo_regs_t q;
    sedo_pkg::sedo_regs_t q_nxt;

    logic                 req_w;
    logic                 still_w;
    logic                 ot_fwd_w;
    logic                 ot_rev_w;
    logic                 opp_w;
    logic                 blocked_w;
    logic                 ot_stop_w;
    logic                 energized_w;
    logic signed [15:0]   cmd_gated_w;
    logic                 acc_w;
    logic                 start_w;
    logic [31:0]          status_w;

    always_comb begin
        q_nxt       = q;
        req_w       = route_select(q.cfg.route, s_son_n, s_terms_n);
        still_w     = abs16(motor_speed_i) <= q.thresh;
        ot_fwd_w    = ~s_fwd_ok;
        ot_rev_w    = ~s_rev_ok;
        blocked_w   = (ot_fwd_w && cmd_i > 0) || (ot_rev_w && cmd_i < 0);
        opp_w       = (ot_fwd_w && cmd_i < 0) || (ot_rev_w && cmd_i > 0);
        cmd_gated_w = blocked_w ? 16'sh0000 : cmd_i;
        acc_w       = (avs_read_i || avs_write_i) && q.wait_n;
        start_w     = (avs_read_i || avs_write_i) && !q.wait_n;
        q_nxt.arst  = 1'b0;

        // --------------------------------------------------------------------
        // Energize state machine
        // --------------------------------------------------------------------
        unique case (q.st)
            sedo_pkg::SEDO_ST_OFF: begin
                // Forced mode makes the request constant, so power-up alone
                // energizes once the shaft is at rest.
                if (alarm_i) begin
                    q_nxt.st = sedo_pkg::SEDO_ST_FAULT;
                end else if (req_w && s_power && still_w) begin
                    q_nxt.st = sedo_pkg::SEDO_ST_ON;
                end
            end
            sedo_pkg::SEDO_ST_ON: begin
                if (alarm_i) begin
                    q_nxt.st = sedo_pkg::SEDO_ST_FAULT;
                end else if (!req_w || !s_power) begin
                    q_nxt.st = sedo_pkg::SEDO_ST_OFF;
                end
            end
            sedo_pkg::SEDO_ST_FAULT: begin
                // Reset returns to OFF; in forced mode OFF re-energizes.
                if (q.arst && !alarm_i) begin
                    q_nxt.st = sedo_pkg::SEDO_ST_OFF;
                end
            end
            default: begin
                q_nxt.st = sedo_pkg::SEDO_ST_OFF;
            end
        endcase

        // --------------------------------------------------------------------
        // Motor side outputs
        // --------------------------------------------------------------------
        energized_w     = q_nxt.st == sedo_pkg::SEDO_ST_ON;
        ot_stop_w       = energized_w && (ot_fwd_w || ot_rev_w) && still_w && !opp_w;
        q_nxt.clamp     = ot_stop_w && q.cfg.ot_clamp;
        q_nxt.bblock    = ot_stop_w && !q.cfg.ot_clamp;
        q_nxt.motor_en  = energized_w && !q_nxt.bblock;
        q_nxt.brake_rel = energized_w && !(ot_fwd_w || ot_rev_w);
        if (!energized_w || q_nxt.clamp || q_nxt.bblock) begin
            q_nxt.drive_cmd = `SEDO_CMD_ZERO;
        end else begin
            // Direction field 1 negates the command sign; field 0 passes the command unchanged.
            q_nxt.drive_cmd = q.cfg.dir_cw ? neg16(cmd_gated_w) : cmd_gated_w;
        end
        // Swapping channels cancels the reversed shaft rotation seen by the
        // encoder, so the lead phase still follows the command sign.
        q_nxt.pulse_a = q.cfg.dir_cw ? s_enc_b : s_enc_a;
        q_nxt.pulse_b = q.cfg.dir_cw ? s_enc_a : s_enc_b;

        // --------------------------------------------------------------------
        // Avalon-MM slave: one wait cycle, then the answer
        // --------------------------------------------------------------------
        status_w = `SEDO_WORD_ZERO;
        status_w[`SEDO_STAT_ENERGIZED] = q.st == sedo_pkg::SEDO_ST_ON;
        status_w[`SEDO_STAT_OT_FWD]    = ot_fwd_w;
        status_w[`SEDO_STAT_OT_REV]    = ot_rev_w;
        status_w[`SEDO_STAT_BRAKE_ON]  = ~q.brake_rel;
        status_w[`SEDO_STAT_CLAMP]     = q.clamp;
        status_w[`SEDO_STAT_BBLOCK]    = q.bblock;
        status_w[`SEDO_STAT_FAULT]     = q.st == sedo_pkg::SEDO_ST_FAULT;
        status_w[`SEDO_STAT_STILL]     = still_w;
        status_w[`SEDO_STAT_REQ]       = req_w;

        // Read data are captured at the edge that first sees the request, so
        // they stand while waitrequest is low; writes commit at that later edge.
        q_nxt.wait_n = start_w;
        q_nxt.rdata  = `SEDO_WORD_ZERO;
        if (start_w && avs_read_i) begin
            unique case (avs_address_i)
                `SEDO_ADDR_CTRL: begin
                    q_nxt.rdata[`SEDO_CTRL_ROUTE_MSB:`SEDO_CTRL_ROUTE_LSB] = q.cfg.route;
                    q_nxt.rdata[`SEDO_CTRL_DIR_BIT]   = q.cfg.dir_cw;
                    q_nxt.rdata[`SEDO_CTRL_CLAMP_BIT] = q.cfg.ot_clamp;
                end
                `SEDO_ADDR_STATUS: begin
                    q_nxt.rdata = status_w;
                end
                `SEDO_ADDR_THRESH: begin
                    q_nxt.rdata[`SEDO_THRESH_W-1:0] = q.thresh;
                end
                default: begin
                    q_nxt.rdata = `SEDO_WORD_ZERO;
                end
            endcase
        end
        if (acc_w && avs_write_i) begin
            if (avs_address_i == `SEDO_ADDR_CTRL) begin
                if (avs_byteenable_i[0]) begin
                    q_nxt.cfg.route    =
                        avs_writedata_i[`SEDO_CTRL_ROUTE_MSB:`SEDO_CTRL_ROUTE_LSB];
                    q_nxt.cfg.dir_cw   = avs_writedata_i[`SEDO_CTRL_DIR_BIT];
                    q_nxt.cfg.ot_clamp = avs_writedata_i[`SEDO_CTRL_CLAMP_BIT];
                end
                if (avs_byteenable_i[1]) begin
                    q_nxt.arst = avs_writedata_i[`SEDO_CTRL_ARST_BIT];
                end
            end else if (avs_address_i == `SEDO_ADDR_THRESH) begin
                if (avs_byteenable_i[0]) begin
                    q_nxt.thresh[7:0] = avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    q_nxt.thresh[15:8] = avs_writedata_i[15:8];
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q            <= '0;
            q.st         <= sedo_pkg::SEDO_ST_OFF;
            q.cfg.route  <= `SEDO_ROUTE_RST;
            q.thresh     <= `SEDO_THRESH_RST;
        end else begin
            q <= q_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign avs_readdata_o      = q.rdata;
    assign avs_waitrequest_o   = ~q.wait_n;
    assign motor_enable_o      = q.motor_en;
    assign drive_cmd_o         = q.drive_cmd;
    assign brake_release_out_o = q.brake_rel;
    assign zero_clamp_o        = q.clamp;
    assign base_block_o        = q.bblock;
    assign divided_pulse_a_o   = q.pulse_a;
    assign divided_pulse_b_o   = q.pulse_b;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_off_undriven;
        q.st != sedo_pkg::SEDO_ST_ON |-> !motor_enable_o && drive_cmd_o == 16'sh0000;
    endproperty
    a_off_undriven: assert property (p_off_undriven) else $error("motor driven while off");

    property p_on_at_rest;
        $rose(q.st == sedo_pkg::SEDO_ST_ON) |-> $past(still_w);
    endproperty
    a_on_at_rest: assert property (p_on_at_rest) else $error("energized while rotating");

    property p_forced_on;
        q.st == sedo_pkg::SEDO_ST_OFF && q.cfg.route == `SEDO_ROUTE_FORCED && s_power
            && still_w && !alarm_i |=> q.st == sedo_pkg::SEDO_ST_ON;
    endproperty
    a_forced_on: assert property (p_forced_on) else $error("forced mode not energized");

    property p_fault_reset;
        q.st == sedo_pkg::SEDO_ST_FAULT && q.arst && !alarm_i
            |=> q.st == sedo_pkg::SEDO_ST_OFF;
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("alarm reset ignored");

    property p_dir_map;
        q_nxt.st == sedo_pkg::SEDO_ST_ON && !blocked_w && !ot_stop_w && cmd_i != 16'sh8000
            |=> drive_cmd_o == ($past(q.cfg.dir_cw) ? -$past(cmd_i) : $past(cmd_i));
    endproperty
    a_dir_map: assert property (p_dir_map) else $error("direction mapping wrong");

    property p_pulse_phase;
        q.cfg.dir_cw ##1 q.cfg.dir_cw |-> divided_pulse_a_o == $past(s_enc_b, 1)
            && divided_pulse_b_o == $past(s_enc_a, 1);
    endproperty
    a_pulse_phase: assert property (p_pulse_phase) else $error("pulse phase not kept");

    property p_limit_block;
        blocked_w |=> drive_cmd_o == 16'sh0000;
    endproperty
    a_limit_block: assert property (p_limit_block) else $error("limit did not block");

    property p_base_block;
        ot_stop_w && !q.cfg.ot_clamp |=> base_block_o && !motor_enable_o && !zero_clamp_o;
    endproperty
    a_base_block: assert property (p_base_block) else $error("no base block");

    property p_brake_ot;
        (ot_fwd_w || ot_rev_w) |=> !brake_release_out_o;
    endproperty
    a_brake_ot: assert property (p_brake_ot) else $error("brake released in overtravel");

    property p_clamp;
        ot_stop_w && q.cfg.ot_clamp |=> zero_clamp_o && motor_enable_o && !base_block_o;
    endproperty
    a_clamp: assert property (p_clamp) else $error("zero clamp not held");

    property p_opposite;
        q_nxt.st == sedo_pkg::SEDO_ST_ON && opp_w && !blocked_w
            |=> motor_enable_o && drive_cmd_o != 16'sh0000;
    endproperty
    a_opposite: assert property (p_opposite) else $error("opposite motion refused");

endmodule

/* File: tb/sedo_host_model.sv */
// Host controller and normally closed limit switches facing the servo enable block.
`timescale 1ns/1ps

module sedo_host_model (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    // Wishes of the bench
    input  wire logic               want_on_i,
    input  wire logic signed [15:0] want_cmd_i,
    input  wire logic               fwd_end_i,
    input  wire logic               rev_end_i,
    // Seen from the drive
    input  wire logic               motor_enable_i,
    // Driven into the drive
    output logic                    servo_on_n_o,
    output logic signed [15:0]      cmd_o,
    output logic                    forward_limit_in_o,
    output logic                    reverse_limit_in_o
);
    logic ready_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            servo_on_n_o       <= 1'b1;
            ready_r            <= 1'b0;
            cmd_o              <= 16'sh0000;
            forward_limit_in_o <= 1'b1;
            reverse_limit_in_o <= 1'b1;
        end else begin
            servo_on_n_o       <= !want_on_i;
            // Commands follow the first energized cycle and stay offered during
            // base block, so a move away from a limit can still be requested.
            ready_r            <= want_on_i && (ready_r || motor_enable_i);
            cmd_o              <= ready_r ? want_cmd_i : 16'sh0000;
            // Switches open at the end of travel, so a broken wire reads as a stop.
            forward_limit_in_o <= !fwd_end_i;
            reverse_limit_in_o <= !rev_end_i;
        end
    end
endmodule

/* File: tb/servo_enable_direction_overtravel_tb.sv */
// Self-checking testbench of the servo enable, direction and overtravel block.
`timescale 1ns/1ps
`include "sedo_map.svh"

module servo_enable_direction_overtravel_tb;
    logic               clock, rst_n, rd, wr, son, fend, rend, pwr, alarm, ea, eb;
    logic               son_n, flim, rlim, wait_r, m_en, brk, clamp, bb, pa, pb;
    logic [3:0]         addr;
    logic [7:0]         terms_n;
    logic [31:0]        wdata, rdata, q;
    logic signed [15:0] speed, want_cmd, cmd, dcmd;
    int                 errors, comparisons;

    sedo_host_model host_u (.clock_i(clock), .rst_n_i(rst_n), .want_on_i(son),
        .want_cmd_i(want_cmd), .fwd_end_i(fend), .rev_end_i(rend), .motor_enable_i(m_en),
        .servo_on_n_o(son_n), .cmd_o(cmd), .forward_limit_in_o(flim),
        .reverse_limit_in_o(rlim));

    sedo_top #(.NUM_TERMS(8)) dut_u (.clock_i(clock), .rst_n_i(rst_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
        .servo_on_n_i(son_n), .input_terms_n_i(terms_n), .forward_limit_in_i(flim),
        .reverse_limit_in_i(rlim), .main_power_i(pwr), .enc_a_i(ea), .enc_b_i(eb),
        .alarm_i(alarm), .motor_speed_i(speed), .cmd_i(cmd), .motor_enable_o(m_en),
        .drive_cmd_o(dcmd), .brake_release_out_o(brk), .zero_clamp_o(clamp),
        .base_block_o(bb), .divided_pulse_a_o(pa), .divided_pulse_b_o(pb));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wait_r !== 1'b0) begin
            errors++;
            wrap_up();
        end
        @(posedge clock);
    endtask

    // Covers the host register, the two synchroniser flops, the state update,
    // the host's command hand-off and the output stage, with margin.
    task automatic settle();
        repeat (10) @(posedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        {rst_n, rd, wr, son, fend, rend, pwr, alarm, ea, eb} = '0;
        {addr, wdata, speed, want_cmd, errors, comparisons} = '0;
        terms_n = 8'hFF;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(1'b0, `SEDO_ADDR_CTRL, 0);   chk("ctrl", q, 0);
        bus(1'b0, `SEDO_ADDR_THRESH, 0); chk("thresh", q, 32'h0000_0010);
        bus(1'b0, 4'hC, 0);              chk("unmapped", q, 0);
        $display("test registers done");
        pwr   <= 1'b1;
        speed <= 16'sd100;
        son   <= 1'b1;
        settle(); chk("enable while turning", m_en, 0);
        speed <= 16'sd0;
        settle(); chk("enable at rest", m_en, 1);
        bus(1'b0, `SEDO_ADDR_STATUS, 0); chk("energized", q[0], 1);
        son <= 1'b0;
        want_cmd <= 16'sd100;
        settle(); chk("enable off", m_en, 0);
        chk("drive off", dcmd, 0);
        $display("test servo on done");
        son <= 1'b1;
        settle(); chk("ccw cmd", dcmd, 100);
        chk("brake released", brk, 1);
        bus(1'b1, `SEDO_ADDR_CTRL, 32'h0000_0010);
        settle(); chk("cw cmd", dcmd, -100);
        ea <= 1'b1;
        settle(); chk("pulses cw", {pa, pb}, 2'b01);
        bus(1'b1, `SEDO_ADDR_CTRL, 0);
        settle(); chk("pulses ccw", {pa, pb}, 2'b10);
        $display("test direction done");
        rend <= 1'b1;
        want_cmd <= -16'sd100;
        settle(); chk("rev blocked", dcmd, 0);
        want_cmd <= 16'sd100;
        settle(); chk("rev away", dcmd, 100);
        chk("brake rev", brk, 0);
        rend <= 1'b0;
        fend <= 1'b1;
        settle(); chk("fwd blocked", dcmd, 0);
        want_cmd <= -16'sd100;
        settle(); chk("fwd away", dcmd, -100);
        bus(1'b1, `SEDO_ADDR_CTRL, 32'h0000_0020);
        want_cmd <= 16'sd0;
        settle(); chk("clamp", clamp, 1);
        chk("clamp enabled", m_en, 1);
        bus(1'b1, `SEDO_ADDR_CTRL, 0);
        settle(); chk("base block", bb, 1);
        chk("bb enable", m_en, 0);
        chk("brake fwd", brk, 0);
        $display("test overtravel done");
        fend <= 1'b0;
        son  <= 1'b0;
        bus(1'b1, `SEDO_ADDR_CTRL, 32'h0000_0009);
        settle(); chk("forced on", m_en, 1);
        pwr <= 1'b0;
        settle(); chk("forced no power", m_en, 0);
        pwr <= 1'b1;
        settle(); chk("forced power up", m_en, 1);
        alarm <= 1'b1;
        settle(); chk("alarm off", m_en, 0);
        alarm <= 1'b0;
        settle(); chk("fault held", m_en, 0);
        bus(1'b1, `SEDO_ADDR_CTRL, 32'h0000_0109);
        settle(); chk("alarm reset", m_en, 1);
        $display("test forced mode done");
        bus(1'b1, `SEDO_ADDR_CTRL, 32'h0000_0003);
        terms_n <= 8'hFB;
        settle(); chk("terminal on", m_en, 1);
        terms_n <= 8'hFF;
        settle(); chk("terminal off", m_en, 0);
        $display("test routing done");
        wrap_up();
    end
endmodule
